/* File: rtl/sfp_regs.svh */
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// -----------------------------------------------------------------
// Serial pin interface constants
// -----------------------------------------------------------------
// Bits in one transfer unit
`define SFP_BYTE_W 8
// Width of the bit counter within a byte
`define SFP_CNT_W 3
// Bit counter value of the last bit of a byte
`define SFP_LAST_BIT 3'h7
// Width of the memory address checked against the protected area
`define SFP_ADDR_W 20
// Number of pins passed through the synchroniser
`define SFP_PIN_N 5
// Pin positions inside the synchroniser vector
`define SFP_PIN_CS 0
`define SFP_PIN_SCK 1
`define SFP_PIN_SI 2
`define SFP_PIN_HOLD 3
`define SFP_PIN_WP 4
// Synchroniser reset value: select high, pause and protect released
`define SFP_PIN_RST 5'h19
// Reset values of the shift and data registers and of the bit counter
`define SFP_BYTE_RST 8'h00
`define SFP_CNT_RST 3'h0

`endif

/* File: rtl/sfp_pkg.sv */
`include "sfp_regs.svh"
`default_nettype none

package sfp_pkg;

  // -----------------------------------------------------------------
  // Interface states
  // -----------------------------------------------------------------
  typedef enum logic [3:0] {
    SFP_ST_UNARMED = 4'b0001,
    SFP_ST_DESEL = 4'b0010,
    SFP_ST_XFER = 4'b0100,
    SFP_ST_PAUSE = 4'b1000
  } sfp_state_t;

  // Protected area decode from the three area bits
  function automatic logic sfp_in_area(input logic [`SFP_ADDR_W-1:0] addr,
                                       input logic [2:0] area);
    logic hit;
    hit = 1'b0;
    unique case (area)
      3'h0: hit = 1'b0;
      3'h1: hit = (addr[19:16] == 4'hf);
      3'h2: hit = (addr[19:17] == 3'h7);
      3'h3: hit = (addr[19:18] == 2'h3);
      3'h4: hit = addr[19];
      default: hit = 1'b1;
    endcase
    return hit;
  endfunction : sfp_in_area

endpackage : sfp_pkg

`default_nettype wire

/* File: rtl/sfp_sync.sv */
`include "sfp_regs.svh"
`default_nettype none

module sfp_sync #(
  parameter int WIDTH = `SFP_PIN_N,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);

  // -----------------------------------------------------------------
  // Two-stage synchronisers, one per pin
  // -----------------------------------------------------------------
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          stage1_reg[i] <= RST_VAL[i];
          stage2_reg[i] <= RST_VAL[i];
        end else begin
          stage1_reg[i] <= pin_async[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign pin_sync = stage2_reg;

endmodule : sfp_sync

`default_nettype wire

/* File: rtl/sfp_pin_if.sv */
`include "sfp_regs.svh"
`default_nettype none

// How it works
// - Input bits are taken on each rising serial clock edge.
// - Output bits change on falling serial clock edges and on the select falling edge.
// - Select low makes the device active and starts a transfer.
// - Select high deselects and leaves the output undriven.
// - No byte is accepted before a first select falling edge.
// - Standby only once deselected and no internal operation is busy.
// - Pause low undrives output and ignores clock and data, keeping state.
// - Protect low blocks program or erase inside the chosen area.
// - Clock idle low or idle high both work, rising in, falling out.
// - Transfers are whole bytes of eight bits.
// - Select rising during a pause resets the interface logic.
module sfp_pin_if
  import sfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe_n,
  input wire logic [`SFP_BYTE_W-1:0] tx_data,
  output logic tx_taken,
  output logic [`SFP_BYTE_W-1:0] rx_data,
  output logic rx_valid,
  output logic frame_partial,
  input wire logic op_busy,
  output logic standby,
  output logic active_mode,
  output logic hold_active,
  output logic armed,
  input wire logic [`SFP_ADDR_W-1:0] prog_addr,
  input wire logic [2:0] protect_area_bits,
  output logic write_blocked
);

  // -----------------------------------------------------------------
  // Pin synchronisers and edge finding
  // -----------------------------------------------------------------
  logic [`SFP_PIN_N-1:0] pins_async;
  logic [`SFP_PIN_N-1:0] pins_sync;
  logic sck_prev_reg;
  logic cs_prev_reg;

  assign pins_async = {wp_n, hold_n, si, sck, cs_n};

  sfp_sync #(
    .WIDTH(`SFP_PIN_N),
    .RST_VAL(`SFP_PIN_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_async(pins_async),
    .pin_sync(pins_sync)
  );

  wire cs_s = pins_sync[`SFP_PIN_CS];
  wire sck_s = pins_sync[`SFP_PIN_SCK];
  wire si_s = pins_sync[`SFP_PIN_SI];
  wire hold_n_s = pins_sync[`SFP_PIN_HOLD];
  wire wp_n_s = pins_sync[`SFP_PIN_WP];

  // Previous levels for edge detection
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sck_prev_reg <= sck_s;
      cs_prev_reg <= cs_s;
    end
  end

  // both clock idles
  // Edges; either clock idle level works
  wire sck_rise = sck_s & ~sck_prev_reg;
  wire sck_fall = ~sck_s & sck_prev_reg;
  wire cs_fall = cs_prev_reg & ~cs_s;
  wire cs_rise = ~cs_prev_reg & cs_s;

  // -----------------------------------------------------------------
  // Interface state machine
  // -----------------------------------------------------------------
  sfp_state_t state_reg;
  sfp_state_t state_next;

  // Pause starts or ends with clock low, else at the next falling edge
  wire hold_enter = ~hold_n_s & (~sck_s | sck_fall);
  wire hold_exit = hold_n_s & (~sck_s | sck_fall);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SFP_ST_UNARMED: begin
        if (cs_fall) begin
          state_next = SFP_ST_XFER;
        end
      end
      SFP_ST_DESEL: begin
        if (cs_fall) begin
          state_next = SFP_ST_XFER;
        end
      end
      SFP_ST_XFER: begin
        if (cs_s) begin
          state_next = SFP_ST_DESEL;
        end else if (hold_enter) begin
          state_next = SFP_ST_PAUSE;
        end
      end
      SFP_ST_PAUSE: begin
        if (cs_s) begin
          state_next = SFP_ST_DESEL;
        end else if (hold_exit) begin
          state_next = SFP_ST_XFER;
        end
      end
      default: state_next = SFP_ST_DESEL;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= SFP_ST_UNARMED;
    end else begin
      state_reg <= state_next;
    end
  end

  wire in_xfer = (state_reg == SFP_ST_XFER) & ~cs_s;
  wire start_load = cs_fall & (state_reg != SFP_ST_XFER) & (state_reg != SFP_ST_PAUSE);

  // -----------------------------------------------------------------
  // Receive shifter
  // -----------------------------------------------------------------
  logic [`SFP_CNT_W-1:0] bit_cnt_reg;
  logic [`SFP_BYTE_W-1:0] rx_shift_reg;
  logic [`SFP_BYTE_W-1:0] rx_data_reg;
  logic rx_valid_reg;
  logic frame_partial_reg;

  wire [`SFP_BYTE_W-1:0] rx_shift_next = {rx_shift_reg[`SFP_BYTE_W-2:0], si_s};
  wire byte_done = in_xfer & sck_rise & (bit_cnt_reg == `SFP_LAST_BIT);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_shift_reg <= `SFP_BYTE_RST;
    end else if (in_xfer && sck_rise) begin
      rx_shift_reg <= rx_shift_next;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bit_cnt_reg <= `SFP_CNT_RST;
    end else if (cs_s || start_load) begin
      bit_cnt_reg <= `SFP_CNT_RST;
    end else if (in_xfer && sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // Completed byte and partial-frame flags
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_data_reg <= `SFP_BYTE_RST;
      rx_valid_reg <= 1'b0;
      frame_partial_reg <= 1'b0;
    end else begin
      rx_valid_reg <= byte_done;
      frame_partial_reg <= cs_rise & (bit_cnt_reg != `SFP_CNT_RST);
      if (byte_done) begin
        rx_data_reg <= rx_shift_next;
      end
    end
  end

  // -----------------------------------------------------------------
  // Transmit shifter
  // -----------------------------------------------------------------
  logic [`SFP_BYTE_W-1:0] tx_shift_reg;
  logic so_reg;
  logic tx_taken_reg;

  wire tx_reload = start_load | (in_xfer & sck_fall & (bit_cnt_reg == `SFP_CNT_RST));
  wire tx_step = in_xfer & sck_fall & (bit_cnt_reg != `SFP_CNT_RST);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_shift_reg <= `SFP_BYTE_RST;
      so_reg <= 1'b0;
      tx_taken_reg <= 1'b0;
    end else begin
      tx_taken_reg <= tx_reload;
      if (tx_reload) begin
        so_reg <= tx_data[`SFP_BYTE_W-1];
        tx_shift_reg <= {tx_data[`SFP_BYTE_W-2:0], 1'b0};
      end else if (tx_step) begin
        so_reg <= tx_shift_reg[`SFP_BYTE_W-1];
        tx_shift_reg <= {tx_shift_reg[`SFP_BYTE_W-2:0], 1'b0};
      end
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  // undriven when deselected or paused
  assign so_oe_n = ~in_xfer;
  assign so_out = so_reg;
  assign tx_taken = tx_taken_reg;
  assign rx_data = rx_data_reg;
  assign rx_valid = rx_valid_reg;
  assign frame_partial = frame_partial_reg;
  assign hold_active = (state_reg == SFP_ST_PAUSE);
  assign armed = (state_reg != SFP_ST_UNARMED);
  assign standby = cs_s & ~op_busy;
  assign active_mode = ~standby;
  assign write_blocked = ~wp_n_s & sfp_in_area(prog_addr, protect_area_bits);

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_paused_desel;
    (state_reg == SFP_ST_PAUSE) && cs_s;
  endsequence

  sequence s_cleared;
    (state_reg == SFP_ST_DESEL) && (bit_cnt_reg == `SFP_CNT_RST);
  endsequence

  sequence s_sel_edge;
    cs_fall && (state_reg == SFP_ST_DESEL);
  endsequence

  a_rx_on_rise: assert property (rx_valid_reg |-> $past(sck_rise) && $past(in_xfer))
    else $error("byte completed without a rising clock");
  a_so_on_fall: assert property ($changed(so_reg) |-> $past(sck_fall) || $past(start_load))
    else $error("output bit changed off a falling clock");
  a_select_active: assert property (s_sel_edge |=> (state_reg == SFP_ST_XFER) && active_mode)
    else $error("select did not start a transfer");
  a_desel_hiz: assert property (cs_s |-> so_oe_n)
    else $error("output driven while deselected");
  a_unarmed_quiet: assert property ($past(state_reg == SFP_ST_UNARMED) |-> !rx_valid_reg)
    else $error("byte accepted before first select");
  a_busy_no_standby: assert property ((op_busy || !cs_s) |-> !standby && active_mode)
    else $error("standby while operation busy");
  a_idle_standby: assert property ((cs_s && !op_busy) |-> standby && !active_mode)
    else $error("idle deselected device not in standby");
  a_pause_hiz: assert property (hold_active |-> so_oe_n && $stable(bit_cnt_reg))
    else $error("pause did not freeze interface");
  a_protect_all: assert property (!wp_n_s && protect_area_bits[2]
                                  && (protect_area_bits[1:0] != 2'h0) |-> write_blocked)
    else $error("protected write not blocked");
  a_byte_whole: assert property (byte_done |=> rx_valid_reg && bit_cnt_reg == `SFP_CNT_RST)
    else $error("byte boundary not at eighth bit");
  a_pause_reset: assert property (s_paused_desel |=> s_cleared)
    else $error("deselect in pause did not reset interface");

endmodule : sfp_pin_if

`default_nettype wire

/* File: dv/sfp_master.sv */
`default_nettype none
// ---------------------------------
// Serial bus master model
// ---------------------------------
module sfp_master (
  input wire logic clk_sys,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cpol;
  // Idle pins: deselected, pause and protect released
  initial begin
    {cs_n, sck, si, hold_n, wp_n, cpol} = 6'h26;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // select toggled before traffic, kept low in pause
  task automatic pins(input logic c, input logic h);
    @(posedge clk_sys);
    cs_n <= c;
    hold_n <= h;
    tick(5);
  endtask : pins
  task automatic wp(input logic v);
    @(posedge clk_sys);
    wp_n <= v;
    tick(4);
  endtask : wp
  // idle clock level of mode 0 or mode 3
  task automatic mode(input logic m);
    @(posedge clk_sys);
    cpol <= m;
    sck <= m;
    tick(4);
  endtask : mode
  // MSB first, out on fall, sample late in high phase
  task automatic shift(input int n, input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      sck <= 1'b0;
      si <= d[7-i];
      tick(4);
      sck <= 1'b1;
      tick(3);
      q[7-i] = so_oe_n ? ~so_out : so_out; // Released line reads inverted
    end
    @(posedge clk_sys);
    sck <= cpol;
    tick(4);
  endtask : shift
endmodule : sfp_master
`default_nettype wire

/* File: dv/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset, op_busy;
  logic [7:0] tx_data, got, rx_last;
  logic [19:0] prog_addr;
  logic [2:0] protect_area_bits;
  wire logic cs_n, sck, si, hold_n, wp_n, so_out, so_oe_n, rx_valid, frame_partial;
  wire logic standby, active_mode, hold_active, armed, write_blocked, tx_taken;
  wire logic [7:0] rx_data;
  int fail_count = 0, check_count = 0, rx_n = 0, fp_n = 0, tx_n = 0, n0, n1;
  logic [19:0] lo [8] = '{20'h0, 20'hf0000, 20'he0000, 20'hc0000, 20'h80000, 20'h0, 20'h0,
    20'h0};
  sfp_master m (.clk_sys(clk_sys), .so_out(so_out), .so_oe_n(so_oe_n), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n));
  sfp_pin_if dut (.clk_sys(clk_sys), .reset(reset), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .tx_data(tx_data),
    .tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid), .frame_partial(frame_partial),
    .op_busy(op_busy), .standby(standby), .active_mode(active_mode),
    .hold_active(hold_active), .armed(armed), .prog_addr(prog_addr),
    .protect_area_bits(protect_area_bits), .write_blocked(write_blocked));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulse counters
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rx_n <= rx_n + 1;
      rx_last <= rx_data;
    end
    if (frame_partial === 1'b1) fp_n <= fp_n + 1;
    if (tx_taken === 1'b1) tx_n <= tx_n + 1;
  end
  task automatic cmp(input string w, input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, w, g, e);
    end
  endtask : cmp
  task automatic conclude();
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic t_arm();
    m.shift(8, 8'hff, got);
    cmp("armed", armed, 0);
    cmp("rx", rx_n, 0);
    cmp("oe", so_oe_n, 1);
    m.pins(0, 1);
    cmp("armed", armed, 1);
    cmp("act", active_mode, 1);
    m.pins(1, 1);
  endtask : t_arm
  task automatic t_byte(input logic md, input logic [7:0] tx, input logic [7:0] d);
    m.mode(md);
    n1 = tx_n;
    tx_data <= tx;
    m.pins(0, 1);
    cmp("oe", so_oe_n, 0);
    n0 = rx_n;
    m.shift(8, d, got);
    cmp("rx", rx_last, d);
    cmp("cnt", rx_n - n0, 1);
    cmp("so", got, tx);
    m.pins(1, 1);
    cmp("oe", so_oe_n, 1);
    cmp("taken", tx_n - n1, 2);
  endtask : t_byte
  task automatic t_part();
    m.pins(0, 1);
    n0 = fp_n;
    m.shift(3, 8'he0, got);
    m.pins(1, 1);
    cmp("part", fp_n - n0, 1);
  endtask : t_part
  task automatic t_pause();
    m.pins(0, 1);
    n0 = rx_n;
    m.shift(4, 8'h5f, got);
    m.pins(0, 0);
    cmp("hold", hold_active, 1);
    cmp("oe", so_oe_n, 1);
    m.shift(4, 8'hf0, got);
    m.pins(0, 1);
    m.shift(4, 8'ha0, got);
    cmp("rx", rx_last, 8'h5a);
    cmp("cnt", rx_n - n0, 1);
    m.shift(3, 8'hff, got);
    m.pins(0, 0);
    m.pins(1, 0);
    cmp("hold", hold_active, 0);
    m.pins(1, 1);
    m.pins(0, 1);
    m.shift(8, 8'hc3, got);
    cmp("rx", rx_last, 8'hc3);
    m.pins(1, 1);
  endtask : t_pause
  task automatic t_standby();
    op_busy <= 1'b1;
    m.tick(2);
    cmp("stby", {standby, active_mode}, 2'b01);
    op_busy <= 1'b0;
    m.tick(2);
    cmp("stby", {standby, active_mode}, 2'b10);
  endtask : t_standby
  task automatic t_prot();
    for (int a = 0; a < 8; a++) begin
      for (int w = 0; w < 2; w++) begin
        for (int k = 0; k < 2; k++) begin
          prog_addr <= lo[a] - 20'(k);
          protect_area_bits <= 3'(a);
          m.wp(w[0]);
          cmp("wb", write_blocked, w == 0 && a != 0 && lo[a] - 20'(k) >= lo[a]);
        end
      end
    end
  endtask : t_prot
  // Watchdog
  initial begin
    m.tick(20000);
    fail_count++;
    conclude();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    op_busy = 1'b0;
    tx_data = 8'h00;
    prog_addr = 20'h00000;
    protect_area_bits = 3'h0;
    m.tick(16);
    reset <= 1'b0;
    m.tick(4);
    t_arm();
    t_byte(0, 8'ha5, 8'h3c);
    t_byte(1, 8'h96, 8'h0f);
    m.mode(0);
    t_part();
    t_pause();
    t_standby();
    t_prot();
    conclude();
  end
endmodule : testbench
`default_nettype wire
